// File: dpbi_pkg.sv
// Constants and types shared by the diskette parameter block interpreter.
`default_nettype none
package dpbi_pkg;
   // =====================================================================
   // Host command byte layout.
   localparam int unsigned    CMD_IRQ_BIT      = 7;
   localparam logic [3:0]     CMD_PARAM_FIRST  = 4'h1;
   localparam logic [3:0]     CMD_PARAM_NEXT   = 4'h2;
   localparam logic [3:0]     CMD_BLOCK_LOAD   = 4'h3;
   localparam logic [3:0]     CMD_BLOCK_READ   = 4'h4;
   localparam logic [3:0]     CMD_RESULT       = 4'h5;
   // =====================================================================
   // Parameter block layout.
   localparam int unsigned    PARAM_BYTES      = 5;
   localparam logic [2:0]     PIDX_CHANNEL     = 3'h0;
   localparam logic [2:0]     PIDX_INSTR       = 3'h1;
   localparam logic [2:0]     PIDX_COUNT       = 3'h2;
   localparam logic [2:0]     PIDX_TRACK       = 3'h3;
   localparam logic [2:0]     PIDX_SECTOR      = 3'h4;
   localparam int unsigned    CH_SEQ_BIT       = 6;
   // =====================================================================
   // Operation codes of the diskette instruction byte.
   localparam logic [2:0]     OP_NOP           = 3'h0;
   localparam logic [2:0]     OP_SEEK          = 3'h1;
   localparam logic [2:0]     OP_FORMAT        = 3'h2;
   localparam logic [2:0]     OP_RECAL         = 3'h3;
   localparam logic [2:0]     OP_READ          = 3'h4;
   localparam logic [2:0]     OP_VERIFY        = 3'h5;
   localparam logic [2:0]     OP_WRITE         = 3'h6;
   localparam logic [2:0]     OP_WRITE_DEL     = 3'h7;
   // =====================================================================
   // Address limits and track geometry.
   localparam logic [7:0]     MAX_TRACK        = 8'h4c;
   localparam logic [7:0]     MIN_SECTOR       = 8'h01;
   localparam logic [7:0]     MAX_SECTOR       = 8'h1a;
   localparam logic [7:0]     SECTORS_PER_TRK  = 8'h1a;
   localparam logic [7:0]     BLOCK_BYTES      = 8'h80;
   localparam int unsigned    BLOCK_SHIFT      = 7;
   localparam logic [7:0]     FILL_BYTE        = 8'he5;
   // =====================================================================
   // Result byte bit positions.
   localparam int unsigned    RES_DELETED      = 0;
   localparam int unsigned    RES_CRC          = 1;
   localparam int unsigned    RES_ADDR         = 2;
   localparam int unsigned    RES_SEEK         = 3;
   localparam logic [7:0]     RESULT_RESET     = 8'h00;
   // =====================================================================
   // Default depth of the data RAM: one full track of 128-byte sectors.
   localparam int unsigned    DATA_DEPTH_DEF   = 3328;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_PARAM,
      ST_LOAD_COUNT,
      ST_LOAD_DATA,
      ST_READ_OUT,
      ST_RESULT_OUT,
      ST_CHECK,
      ST_WR_STREAM,
      ST_FMT_STREAM,
      ST_RD_STREAM,
      ST_WAIT_DONE
   } dpbi_state_t;
endpackage
`default_nettype wire

// File: dpbi_ram_if.sv
// Interface between the interpreter and its data RAM.
`timescale 1ns/10ps
`default_nettype none
interface dpbi_ram_if #(
   parameter int unsigned AW = 12
);
   logic          wr_en;
   logic [AW-1:0] addr;
   logic [7:0]    wdata;
   logic [7:0]    rdata;

   modport ctl (output wr_en, output addr, output wdata, input rdata);
   modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// File: dpbi_ram.sv
// Flip-flop data RAM with combinational read.
`timescale 1ns/10ps
`default_nettype none
module dpbi_ram #(
   parameter int unsigned DEPTH = 3328,
   parameter int unsigned AW    = 12
) (
   input  wire logic sys_clk,
   dpbi_ram_if.mem   ram
);
   logic [7:0] mem [DEPTH];

   initial begin
      if (DEPTH > (1 << AW)) begin
         $error("dpbi_ram depth exceeds address width");
      end
   end

   // =====================================================================
   // Storage.
   always_ff @(posedge sys_clk) begin
      if (ram.wr_en && (32'(ram.addr) < DEPTH)) begin
         mem[ram.addr] <= ram.wdata;
      end
   end

   assign ram.rdata = (32'(ram.addr) < DEPTH) ? mem[ram.addr] : 8'h00;
endmodule
`default_nettype wire

// File: dpbi_top.sv
// Diskette parameter block and data block command interpreter.
`timescale 1ns/10ps
`default_nettype none
module dpbi_top
   import dpbi_pkg::*;
#(
   parameter int unsigned DATA_DEPTH = dpbi_pkg::DATA_DEPTH_DEF
) (
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_byte,
   input  wire logic       in_valid,
   input  wire logic [7:0] in_byte,
   output logic            out_valid,
   output logic [7:0]      out_byte,
   input  wire logic       out_take,
   output logic            busy,
   output logic            dsk_irq,
   output logic            op_complete,
   output logic            dev_error,
   output logic [7:0]      result,
   output logic            fdc_start,
   output logic [2:0]      fdc_op,
   output logic [7:0]      fdc_track,
   output logic [7:0]      fdc_sector,
   output logic [7:0]      fdc_count,
   output logic            fdc_wr_valid,
   output logic [7:0]      fdc_wr_byte,
   output logic            fdc_wr_id,
   input  wire logic       fdc_wr_ready,
   input  wire logic       fdc_rd_valid,
   input  wire logic [7:0] fdc_rd_byte,
   input  wire logic       fdc_done,
   input  wire logic       fdc_crc_err,
   input  wire logic       fdc_deleted,
   input  wire logic       fdc_seek_err
);
   import dpbi_pkg::*;

   localparam int unsigned AW = $clog2(DATA_DEPTH);

   initial begin
      if (DATA_DEPTH < 32'(BLOCK_BYTES) || DATA_DEPTH > 32640) begin
         $error("dpbi_top DATA_DEPTH out of range");
      end
   end

   dpbi_state_t state;
   logic [7:0]  param [PARAM_BYTES];
   logic [2:0]  pidx;
   logic        irq_req;
   logic [14:0] addr;
   logic [14:0] remain;
   logic [14:0] read_len;
   logic [7:0]  fmt_sec;
   logic [7:0]  fmt_pos;
   logic        finish;
   logic [7:0]  next_result;
   logic [7:0]  cnt_eff;
   logic [14:0] cnt_bytes;
   logic [8:0]  span;
   logic        addr_err;
   logic        needs_sector;
   logic        needs_track;
   logic        result_taken;
   logic [2:0]  op;

   dpbi_ram_if #(.AW(AW)) ram ();

   dpbi_ram #(
      .DEPTH (DATA_DEPTH),
      .AW    (AW)
   ) u_ram (
      .sys_clk (sys_clk),
      .ram     (ram)
   );

   // =====================================================================
   // Parameter decode and address checking.
   assign op        = param[PIDX_INSTR][2:0];
   assign cnt_eff   = (param[PIDX_COUNT] == 8'h00) ? 8'h01 : param[PIDX_COUNT];
   assign cnt_bytes = 15'(cnt_eff) << BLOCK_SHIFT;
   assign span      = 9'(param[PIDX_SECTOR]) + 9'(param[PIDX_COUNT]);

   always_comb begin
      needs_sector = 1'b0;
      needs_track  = 1'b0;
      case (op)
         OP_SEEK, OP_FORMAT: begin
            needs_track = 1'b1;
         end
         OP_READ, OP_VERIFY, OP_WRITE, OP_WRITE_DEL: begin
            needs_track  = 1'b1;
            needs_sector = 1'b1;
         end
         default: begin
            needs_track = 1'b0;
         end
      endcase
      addr_err = (needs_track && param[PIDX_TRACK] > MAX_TRACK)
               || (needs_sector && (param[PIDX_SECTOR] < MIN_SECTOR
                                    || param[PIDX_SECTOR] > MAX_SECTOR
                                    || span > 9'(MAX_SECTOR)));
   end

   assign result_taken = (state == ST_RESULT_OUT) && out_valid && out_take;

   // =====================================================================
   // Main sequencer.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= ST_IDLE;
         pidx     <= 3'h0;
         irq_req  <= 1'b0;
         addr     <= 15'h0000;
         remain   <= 15'h0000;
         read_len <= 15'h0000;
         fmt_sec  <= 8'h00;
         fmt_pos  <= 8'h00;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmd_valid) begin
                  irq_req <= cmd_byte[CMD_IRQ_BIT];
                  case (cmd_byte[3:0])
                     CMD_PARAM_FIRST: begin
                        pidx  <= PIDX_CHANNEL;
                        state <= ST_PARAM;
                     end
                     CMD_PARAM_NEXT: begin
                        // A stray next-byte command without a started block is dropped.
                        if (pidx != PIDX_CHANNEL) begin
                           state <= ST_PARAM;
                        end
                     end
                     CMD_BLOCK_LOAD: begin
                        state <= ST_LOAD_COUNT;
                     end
                     CMD_BLOCK_READ: begin
                        addr   <= 15'h0000;
                        remain <= read_len;
                        state  <= (read_len == 15'h0000) ? ST_IDLE : ST_READ_OUT;
                     end
                     CMD_RESULT: begin
                        state <= ST_RESULT_OUT;
                     end
                     default: begin
                        state <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_PARAM: begin
               if (in_valid) begin
                  if (pidx == PIDX_SECTOR) begin
                     pidx  <= PIDX_CHANNEL;
                     state <= ST_CHECK;
                  end else begin
                     pidx  <= pidx + 3'h1;
                     state <= ST_IDLE;
                  end
               end
            end
            ST_LOAD_COUNT: begin
               if (in_valid) begin
                  addr   <= 15'h0000;
                  remain <= 15'(in_byte) << BLOCK_SHIFT;
                  state  <= (in_byte == 8'h00) ? ST_IDLE : ST_LOAD_DATA;
               end
            end
            ST_LOAD_DATA: begin
               if (in_valid) begin
                  addr   <= addr + 15'h0001;
                  remain <= remain - 15'h0001;
                  if (remain == 15'h0001) begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_READ_OUT: begin
               if (out_valid && out_take) begin
                  addr   <= addr + 15'h0001;
                  remain <= remain - 15'h0001;
                  if (remain == 15'h0001) begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_RESULT_OUT: begin
               if (result_taken) begin
                  state <= ST_IDLE;
               end
            end
            ST_CHECK: begin
               addr    <= 15'h0000;
               remain  <= cnt_bytes;
               fmt_sec <= 8'h00;
               fmt_pos <= 8'h00;
               if (addr_err || op == OP_NOP) begin
                  state <= ST_IDLE;
               end else begin
                  case (op)
                     OP_WRITE, OP_WRITE_DEL: begin
                        state <= ST_WR_STREAM;
                     end
                     OP_FORMAT: begin
                        state <= ST_FMT_STREAM;
                     end
                     OP_READ: begin
                        read_len <= cnt_bytes;
                        state    <= ST_RD_STREAM;
                     end
                     default: begin
                        state <= ST_WAIT_DONE;
                     end
                  endcase
               end
            end
            ST_WR_STREAM: begin
               if (fdc_done) begin
                  state <= ST_IDLE;
               end else if (fdc_wr_ready) begin
                  addr   <= addr + 15'h0001;
                  remain <= remain - 15'h0001;
                  if (remain == 15'h0001) begin
                     state <= ST_WAIT_DONE;
                  end
               end
            end
            ST_FMT_STREAM: begin
               if (fdc_done) begin
                  state <= ST_IDLE;
               end else if (fdc_wr_ready) begin
                  if (fmt_pos == BLOCK_BYTES) begin
                     fmt_pos <= 8'h00;
                     fmt_sec <= fmt_sec + 8'h01;
                     if (fmt_sec == SECTORS_PER_TRK - 8'h01) begin
                        state <= ST_WAIT_DONE;
                     end
                  end else begin
                     fmt_pos <= fmt_pos + 8'h01;
                  end
               end
            end
            ST_RD_STREAM: begin
               if (fdc_done) begin
                  state <= ST_IDLE;
               end else if (fdc_rd_valid) begin
                  addr <= addr + 15'h0001;
               end
            end
            ST_WAIT_DONE: begin
               if (fdc_done) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // Parameter block storage.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < PARAM_BYTES; i++) begin
            param[i] <= 8'h00;
         end
      end else if (state == ST_PARAM && in_valid) begin
         param[pidx] <= in_byte;
      end
   end

   // =====================================================================
   // RAM port steering.
   always_comb begin
      ram.wr_en = 1'b0;
      ram.wdata = in_byte;
      ram.addr  = AW'(addr);
      if (state == ST_LOAD_DATA) begin
         ram.wr_en = in_valid;
      end else if (state == ST_RD_STREAM) begin
         ram.wr_en = fdc_rd_valid && !fdc_done;
         ram.wdata = fdc_rd_byte;
      end else if (state == ST_FMT_STREAM) begin
         // Table entry n sits at byte 2n, the count byte not being stored.
         ram.addr = AW'({fmt_sec, 1'b0});
      end
   end

   // =====================================================================
   // Disk-side byte stream.
   always_comb begin
      fdc_wr_valid = 1'b0;
      fdc_wr_id    = 1'b0;
      fdc_wr_byte  = ram.rdata;
      if (state == ST_WR_STREAM) begin
         fdc_wr_valid = 1'b1;
      end else if (state == ST_FMT_STREAM) begin
         fdc_wr_valid = 1'b1;
         if (fmt_pos == 8'h00) begin
            fdc_wr_id = 1'b1;
            if (param[PIDX_CHANNEL][CH_SEQ_BIT]) begin
               fdc_wr_byte = ram.rdata;
            end else begin
               fdc_wr_byte = fmt_sec + 8'h01;
            end
         end else begin
            fdc_wr_byte = FILL_BYTE;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fdc_start  <= 1'b0;
         fdc_op     <= OP_NOP;
         fdc_track  <= 8'h00;
         fdc_sector <= 8'h00;
         fdc_count  <= 8'h00;
      end else begin
         fdc_start <= (state == ST_CHECK) && !addr_err && op != OP_NOP;
         if (state == ST_CHECK) begin
            fdc_op     <= op;
            fdc_track  <= param[PIDX_TRACK];
            fdc_sector <= param[PIDX_SECTOR];
            fdc_count  <= cnt_eff;
         end
      end
   end

   // =====================================================================
   // Completion, result byte and error flag.
   assign busy   = (state == ST_CHECK) || (state == ST_WR_STREAM) || (state == ST_FMT_STREAM)
                || (state == ST_RD_STREAM) || (state == ST_WAIT_DONE);
   assign finish = (state == ST_CHECK && (addr_err || op == OP_NOP))
                || (busy && state != ST_CHECK && fdc_done);

   always_comb begin
      next_result = RESULT_RESET;
      if (state == ST_CHECK) begin
         next_result[RES_ADDR] = addr_err;
      end else begin
         next_result[RES_DELETED] = fdc_deleted;
         next_result[RES_CRC]     = fdc_crc_err;
         next_result[RES_SEEK]    = fdc_seek_err;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         result <= RESULT_RESET;
      end else if (finish) begin
         result <= next_result;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         op_complete <= 1'b0;
      end else if (finish) begin
         op_complete <= 1'b1;
      end else if (state == ST_IDLE && cmd_valid && cmd_byte[3:0] == CMD_PARAM_FIRST) begin
         op_complete <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         dev_error <= 1'b0;
      end else if (finish && next_result != RESULT_RESET) begin
         dev_error <= 1'b1;
      end else if (result_taken) begin
         dev_error <= 1'b0;
      end
   end

   // =====================================================================
   // Output buffer toward the master.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         out_valid <= 1'b0;
         out_byte  <= 8'h00;
      end else if (out_valid && out_take) begin
         out_valid <= 1'b0;
      end else if (!out_valid && state == ST_READ_OUT) begin
         out_valid <= 1'b1;
         out_byte  <= ram.rdata;
      end else if (!out_valid && state == ST_RESULT_OUT) begin
         out_valid <= 1'b1;
         out_byte  <= result;
      end
   end

   // =====================================================================
   // Diskette device interrupt pulse.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         dsk_irq <= 1'b0;
      end else begin
         dsk_irq <= irq_req
                 && ((state == ST_PARAM && in_valid)
                  || (state == ST_LOAD_DATA && in_valid && remain == 15'h0001)
                  || (state == ST_LOAD_COUNT && in_valid && in_byte == 8'h00)
                  || (state == ST_READ_OUT && out_valid && out_take && remain == 15'h0001));
      end
   end
endmodule
`default_nettype wire

// File: dpbi_checker.sv
// Port assertions for the diskette parameter block interpreter.
`timescale 1ns/10ps
`default_nettype none
module dpbi_checker
   import dpbi_pkg::*;
(
   input wire logic sys_clk, arst_n, out_valid, out_take, busy, dsk_irq, op_complete, dev_error,
   input wire logic fdc_start, fdc_wr_valid, fdc_wr_id, fdc_done, fdc_crc_err, fdc_deleted, fdc_seek_err,
   input wire logic [7:0] out_byte, result, fdc_track, fdc_count, fdc_wr_byte,
   input wire logic [2:0] fdc_op
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   a_start_one_pulse: assert property (fdc_start |-> busy ##1 !fdc_start)
      else $error("start pulse");
   a_start_legal:
      assert property (fdc_start |-> fdc_op != OP_NOP && fdc_track <= MAX_TRACK && fdc_count != 8'h00)
      else $error("illegal start");
   a_format_fill:
      assert property (fdc_wr_valid && !fdc_wr_id && fdc_op == OP_FORMAT |-> fdc_wr_byte == FILL_BYTE)
      else $error("fill byte");
   a_id_in_format:
      assert property (fdc_wr_valid && fdc_wr_id |-> fdc_op == OP_FORMAT && fdc_wr_byte inside {[8'h01:8'h1a]})
      else $error("id byte");
   a_done_completes: assert property (fdc_done && busy |=> op_complete && !busy)
      else $error("no completion");
   a_flags_follow:
      assert property (fdc_done && busy |=> result[3:0] == {$past(fdc_seek_err), 1'b0, $past(fdc_crc_err), $past(fdc_deleted)})
      else $error("result flags");
   a_error_has_cause: assert property ($rose(dev_error) |-> result != RESULT_RESET)
      else $error("empty error");
   a_out_holds: assert property (out_valid && !out_take |=> out_valid && $stable(out_byte))
      else $error("output dropped");
   a_irq_single: assert property (dsk_irq |=> !dsk_irq)
      else $error("irq width");
endmodule
bind dpbi_top dpbi_checker u_chk (.sys_clk, .arst_n, .out_valid, .out_take, .busy, .dsk_irq, .op_complete,
   .dev_error, .fdc_start, .fdc_wr_valid, .fdc_wr_id, .fdc_done, .fdc_crc_err, .fdc_deleted, .fdc_seek_err,
   .out_byte, .result, .fdc_track, .fdc_count, .fdc_wr_byte, .fdc_op);
`default_nettype wire

// File: dpbi_fdc_model.sv
// Behavioural disk controller and drive on the interpreter's disk side.
`timescale 1ns/10ps
`default_nettype none
module dpbi_fdc_model
   import dpbi_pkg::*;
(
   input  wire logic sys_clk, arst_n, slow, fdc_start, fdc_wr_valid,
   input  wire logic [2:0] err_flags, fdc_op,
   input  wire logic [7:0] fdc_count,
   output logic fdc_wr_ready, fdc_rd_valid, fdc_crc_err, fdc_deleted, fdc_seek_err,
   output var logic fdc_done,
   output logic [7:0] fdc_rd_byte
);
   logic        act;
   logic        tick;
   logic [15:0] left;
   assign fdc_wr_ready = act && (tick || !slow);
   assign fdc_rd_valid = fdc_wr_ready && fdc_op == OP_READ && left != 16'h0;
   assign fdc_rd_byte = fdc_rd_valid ? left[7:0] : ~left[7:0];
   // Fault flags are shown only with the end pulse.
   assign fdc_deleted = fdc_done && err_flags[0];
   assign fdc_crc_err = fdc_done && err_flags[1];
   assign fdc_seek_err = fdc_done && err_flags[2];
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         act <= 1'b0;
         tick <= 1'b0;
         left <= 16'h0;
         fdc_done <= 1'b0;
      end else begin
         tick <= !tick;
         fdc_done <= act && left == 16'h0;
         if (fdc_start) begin
            act <= 1'b1;
            // A faulted sector moves no data.
            if (err_flags != 3'h0) left <= 16'h0;
            else if (fdc_op == OP_FORMAT) left <= 16'h0d1a;
            else if (fdc_op == OP_READ || fdc_op[2:1] == 2'h3) left <= {1'b0, fdc_count, 7'h0};
            else left <= 16'h0;
         end else if (act && left == 16'h0) act <= 1'b0;
         else if (fdc_rd_valid || (fdc_wr_valid && fdc_wr_ready)) left <= left - 16'h1;
      end
   end
endmodule
`default_nettype wire

// File: tb_dpbi_top.sv
// Self-checking testbench of the diskette parameter block interpreter.
`timescale 1ns/10ps
`default_nettype none
module tb_dpbi_top;
   import dpbi_pkg::*;
   logic sys_clk = 0, arst_n = 0, cmd_valid = 0, in_valid = 0, out_take = 0, slow = 0;
   logic [7:0] cmd_byte = 0, in_byte = 0;
   logic [2:0] err_flags = 0, fdc_op;
   logic out_valid, busy, dsk_irq, op_complete, dev_error, fdc_start, fdc_wr_valid, fdc_wr_id;
   logic fdc_wr_ready, fdc_rd_valid, fdc_done, fdc_crc_err, fdc_deleted, fdc_seek_err;
   logic [7:0] out_byte, result, fdc_track, fdc_sector, fdc_count, fdc_wr_byte, fdc_rd_byte;
   logic [7:0] ids[$], wq[$];
   int mismatches = 0, compares = 0, starts = 0;
   dpbi_top u_dut (.sys_clk, .arst_n, .cmd_valid, .cmd_byte, .in_valid, .in_byte, .out_valid, .out_byte,
      .out_take, .busy, .dsk_irq, .op_complete, .dev_error, .result, .fdc_start, .fdc_op, .fdc_track,
      .fdc_sector, .fdc_count, .fdc_wr_valid, .fdc_wr_byte, .fdc_wr_id, .fdc_wr_ready, .fdc_rd_valid,
      .fdc_rd_byte, .fdc_done, .fdc_crc_err, .fdc_deleted, .fdc_seek_err);
   dpbi_fdc_model u_fdc (.sys_clk, .arst_n, .slow, .fdc_start, .fdc_wr_valid, .err_flags, .fdc_op,
      .fdc_count, .fdc_wr_ready, .fdc_rd_valid, .fdc_crc_err, .fdc_deleted, .fdc_seek_err, .fdc_done,
      .fdc_rd_byte);
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (fdc_start) starts++;
      if (fdc_wr_valid && fdc_wr_ready && fdc_wr_id) ids.push_back(fdc_wr_byte);
      else if (fdc_wr_valid && fdc_wr_ready && fdc_op != OP_FORMAT) wq.push_back(fdc_wr_byte);
   end
   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // Sends one command (c=1) or data byte (c=0) for a single cycle.
   task automatic send(logic c, logic [7:0] b);
      @(posedge sys_clk);
      cmd_valid <= c;
      in_valid <= !c;
      cmd_byte <= b;
      in_byte <= b;
      @(posedge sys_clk);
      cmd_valid <= 0;
      in_valid <= 0;
   endtask
   task automatic irq_in();
      logic s = 0;
      repeat (3) @(posedge sys_clk) s |= dsk_irq;
      check("irq", s, 1);
   endtask
   task automatic pblk(logic [7:0] ch, op, cnt, trk, sec, logic irq);
      logic [7:0] b[5];
      b = '{ch, op, cnt, trk, sec};
      starts = 0;
      foreach (b[i]) begin
         send(1, {irq, 3'h0, i == 0 ? CMD_PARAM_FIRST : CMD_PARAM_NEXT});
         send(0, b[i]);
         if (irq) irq_in();
      end
   endtask
   task automatic res(logic [7:0] exp);
      int k = 0;
      while (op_complete !== 1'b1) begin
         @(posedge sys_clk);
         k++;
         if (k > 10000) begin
            mismatches++;
            results();
         end
      end
      #1;
      check("result", result, exp);
      check("dev_error", dev_error, exp != 0);
   endtask
   task automatic take(logic [7:0] exp);
      int k = 0;
      #1;
      while (out_valid !== 1'b1 && k < 20) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      check("out", {out_valid, out_byte}, {1'b1, exp});
      // A buffer that never fills has been counted above and ends the run.
      if (out_valid !== 1'b1) results();
      @(posedge sys_clk);
      out_take <= 1;
      @(posedge sys_clk);
      out_take <= 0;
   endtask
   task automatic t_nop_addr();
      logic [23:0] bad[4] = '{24'h004d01, 24'h000000, 24'h00001b, 24'h01001a};
      pblk(8'h00, OP_NOP, 0, 0, 1, 1);
      res(0);
      check("nop start", starts, 0);
      // Each refused block is sent again whole, from its first byte.
      foreach (bad[i]) begin
         pblk(0, OP_READ, bad[i][23:16], bad[i][15:8], bad[i][7:0], 0);
         res(8'h04);
         check("addr start", starts, 0);
      end
      send(1, {4'h0, CMD_RESULT});
      take(8'h04);
      #1;
      check("error cleared", dev_error, 0);
   endtask
   task automatic t_write();
      send(1, {1'b1, 3'h0, CMD_BLOCK_LOAD});
      send(0, 8'h01);
      for (int i = 0; i < 128; i++) send(0, i[7:0]);
      irq_in();
      slow <= 1;
      // The sequence flag is set here and must not matter to a write.
      pblk(8'h40, OP_WRITE, 0, 8'h4c, 8'h1a, 0);
      res(0);
      check("count", fdc_count, 1);
      check("track", fdc_track, 8'h4c);
      check("sector", fdc_sector, 8'h1a);
      check("wbytes", wq.size(), 128);
      foreach (wq[i]) check("wbyte", wq[i], i);
   endtask
   task automatic t_ops();
      logic [7:0] ops[4] = '{OP_SEEK, OP_RECAL, OP_VERIFY, OP_WRITE_DEL};
      foreach (ops[i]) begin
         pblk(0, ops[i], 0, 0, 1, 0);
         res(0);
         check("op", {starts[7:0], fdc_op}, {8'h01, ops[i][2:0]});
      end
   endtask
   task automatic t_format();
      for (int r = 0; r < 2; r++) begin
         send(1, {4'h0, CMD_BLOCK_LOAD});
         send(0, 8'h01);
         for (int i = 0; i < 128; i++) send(0, i[0] ? 8'hff : 8'(26 - i / 2));
         ids.delete();
         pblk({1'b0, r[0], 6'h0}, OP_FORMAT, 0, 8'h05, 8'h01, 0);
         res(0);
         check("fmt track", fdc_track, 8'h05);
         check("ids", ids.size(), 26);
         foreach (ids[i]) check("id", ids[i], r ? 26 - i : i + 1);
      end
   endtask
   task automatic t_read();
      slow <= 0;
      pblk(0, OP_READ, 8'h02, 0, 8'h01, 0);
      res(0);
      send(1, {1'b1, 3'h0, CMD_BLOCK_READ});
      for (int i = 0; i < 256; i++) take(8'(256 - i));
      irq_in();
   endtask
   task automatic t_flags();
      logic [2:0] flg[3] = '{3'h1, 3'h2, 3'h4};
      foreach (flg[i]) begin
         err_flags <= flg[i];
         pblk(0, OP_READ, 0, 0, 1, 0);
         res({4'h0, flg[i][2], 1'b0, flg[i][1:0]});
      end
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      arst_n <= 1;
      t_nop_addr();
      t_write();
      t_ops();
      t_format();
      t_read();
      t_flags();
      results();
   end
endmodule
`default_nettype wire
